// ---- logic/ssr_consts.vh ----
// Constants for the two-wire serial slave read path
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH
`define SSR_ADDR_FIXED      6'b11_0100
`define SSR_DIR_READ        1'b1
`define SSR_PTR_RESET       8'h00
`define SSR_CLK_HZ          20000000
`define SSR_TIMEOUT_MS      35
`define SSR_TIMEOUT_CYCLES  ((`SSR_CLK_HZ / 1000) * `SSR_TIMEOUT_MS)
`define SSR_BIT_LAST        4'h8
`define SSR_FIFO_DEPTH      4
`endif

// ---- logic/ssr_fifo.v ----
// Small valid/ready FIFO carrying register bytes toward the shifter
`timescale 1ns/1ns
module ssr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             reset_n,
  input  wire             flush,
  // Fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  localparam [AW:0] FULL = DEPTH;

  assign in_ready  = (cnt_q != FULL);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk_sys)
  begin
    if (push)
      mem[wr_q] <= in_data;
    if (!reset_n || flush)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // ssr_fifo

// ---- logic/ssr_slave.v ----
// Two-wire serial slave: address match, pointer load, streamed reads
`timescale 1ns/1ns
`include "ssr_consts.vh"
// Functional notes
// - Direction bit one means read transfer
// - Low address bit must match select pin
// - Acknowledge matching address in ninth clock
// - Read data starts at register pointer
// - Pointer persists between transfers
// - Keep sending while master acknowledges
// - Address is 110100 plus select pin
// - Write: first byte loads pointer, rest stored
// - On not-acknowledge release data line high
// - Clock low 35 ms resets interface
module ssr_slave #(
  parameter TIMEOUT_CYCLES = `SSR_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  // Serial pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       address_select_pin,
  // Register file port
  output reg  [7:0] reg_addr,
  input  wire [7:0] reg_rdata,
  output reg  [7:0] reg_wdata,
  output reg        reg_we
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_AACK  = 3'd2;
  localparam ST_WRX   = 3'd3;
  localparam ST_WACK  = 3'd4;
  localparam ST_RTX   = 3'd5;
  localparam ST_RACK  = 3'd6;

  reg  [2:0]  scl_s_q;
  reg  [2:0]  sda_s_q;
  reg  [2:0]  sel_s_q;
  reg         scl_q;
  reg         sda_q;
  reg         sel_q;
  reg  [2:0]  st_q;
  reg  [3:0]  bit_q;
  reg  [7:0]  sh_q;
  reg  [7:0]  ptr_q;
  reg  [7:0]  fetch_q;
  reg         first_q;
  reg         is_read_q;
  reg  [31:0] low_cnt_q;
  reg         drive_low_q;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_c;
  wire        stop_c;
  wire        tmo;
  wire [7:0]  f_data;
  wire        f_valid;
  wire        f_in_ready;
  reg         f_pop;
  reg         f_push;

  // Line counts only once second and third stages agree
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      scl_s_q <= 3'b111;
      sda_s_q <= 3'b111;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      sel_s_q <= 3'b000;
      sel_q   <= 1'b0;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
      if (scl_s_q[1] == scl_s_q[2])
        scl_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2])
        sda_q <= sda_s_q[2];
      sel_s_q <= {sel_s_q[1:0], address_select_pin};
      if (sel_s_q[1] == sel_s_q[2])
        sel_q <= sel_s_q[2];
    end
  end

  assign scl_rise = scl_s_q[1] && scl_s_q[2] && !scl_q;
  assign scl_fall = !scl_s_q[1] && !scl_s_q[2] && scl_q;
  assign start_c  = scl_q && sda_q && !sda_s_q[1] && !sda_s_q[2];
  assign stop_c   = scl_q && !sda_q && sda_s_q[1] && sda_s_q[2];
  assign tmo      = (low_cnt_q >= TIMEOUT_CYCLES - 1);

  // Prefetch buffer decouples register reads from the shift timing
  ssr_fifo #(
    .WIDTH (8),
    .DEPTH (`SSR_FIFO_DEPTH),
    .AW    (2)
  ) i_ssr_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .flush     (start_c || stop_c || tmo || !is_read_q),
    .in_data   (reg_rdata),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  always @*
  begin
    f_push = is_read_q && f_in_ready && (st_q != ST_IDLE) && !start_c && !stop_c;
    f_pop  = (st_q == ST_AACK || st_q == ST_RACK) && scl_fall && f_valid;
  end

  always @(posedge clk_sys)
  begin
    if (!reset_n || scl_q)
      low_cnt_q <= 32'h0000_0000;
    else if (!tmo)
      low_cnt_q <= low_cnt_q + 32'h0000_0001;
  end

  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      st_q        <= ST_IDLE;
      bit_q       <= 4'h0;
      sh_q        <= 8'h00;
      ptr_q       <= `SSR_PTR_RESET;
      fetch_q     <= `SSR_PTR_RESET;
      first_q     <= 1'b0;
      is_read_q   <= 1'b0;
      drive_low_q <= 1'b0;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
      reg_addr    <= `SSR_PTR_RESET;
      reg_wdata   <= 8'h00;
      reg_we      <= 1'b0;
    end
    else
    begin
      reg_we   <= 1'b0;
      sda_out  <= 1'b0;
      sda_oe   <= drive_low_q;
      // Address runs one ahead of each push so every byte is fetched once
      reg_addr <= is_read_q ? (f_push ? fetch_q + 8'h01 : fetch_q) : ptr_q;
      if (f_push)
        fetch_q <= fetch_q + 8'h01;
      if (tmo || stop_c)
      begin
        st_q        <= ST_IDLE;
        is_read_q   <= 1'b0;
        drive_low_q <= 1'b0;
        sda_oe      <= 1'b0;
      end
      else if (start_c)
      begin
        st_q        <= ST_ADDR;
        bit_q       <= 4'h0;
        is_read_q   <= 1'b0;
        drive_low_q <= 1'b0;
        sda_oe      <= 1'b0;
      end
      else
      begin
        case (st_q)
          ST_ADDR, ST_WRX:
          begin
            if (scl_rise)
            begin
              sh_q  <= {sh_q[6:0], sda_q};
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == `SSR_BIT_LAST)
            begin
              bit_q <= 4'h0;
              if (st_q == ST_WRX)
              begin
                drive_low_q <= 1'b1;
                st_q        <= ST_WACK;
                if (first_q)
                begin
                  ptr_q   <= sh_q;
                  first_q <= 1'b0;
                end
                else
                begin
                  reg_wdata <= sh_q;
                  reg_we    <= 1'b1;
                  ptr_q     <= ptr_q + 8'h01;
                end
              end
              else if (sh_q[7:2] == `SSR_ADDR_FIXED
                       && sh_q[1] == sel_q)
              begin
                drive_low_q <= 1'b1;
                st_q        <= ST_AACK;
                first_q     <= 1'b1;
                is_read_q   <= (sh_q[0] == `SSR_DIR_READ);
                fetch_q     <= ptr_q;
              end
              else
                st_q <= ST_IDLE;
            end
          end
          ST_WACK:
          begin
            if (scl_fall)
            begin
              drive_low_q <= 1'b0;
              st_q        <= ST_WRX;
            end
          end
          ST_AACK, ST_RACK:
          begin
            if (scl_fall && st_q == ST_RACK && sda_q)
            begin
              drive_low_q <= 1'b0;
              st_q        <= ST_IDLE;
            end
            else if (scl_fall && !is_read_q)
            begin
              drive_low_q <= 1'b0;
              st_q        <= ST_WRX;
            end
            else if (scl_fall)
            begin
              // Empty buffer sends ones rather than stalling the master clock
              sh_q        <= f_valid ? {f_data[6:0], 1'b1} : 8'hFF;
              drive_low_q <= f_valid ? !f_data[7] : 1'b0;
              ptr_q       <= ptr_q + 8'h01;
              bit_q       <= 4'h1;
              st_q        <= ST_RTX;
            end
          end
          ST_RTX:
          begin
            if (scl_fall)
            begin
              if (bit_q == `SSR_BIT_LAST)
              begin
                drive_low_q <= 1'b0;
                st_q        <= ST_RACK;
              end
              else
              begin
                drive_low_q <= !sh_q[7];
                sh_q        <= {sh_q[6:0], 1'b1};
                bit_q       <= bit_q + 4'h1;
              end
            end
          end
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // ssr_slave

// ---- bench/ssr_slave_props.sv ----
// Pin-level assertions for the serial slave
`timescale 1ns/1ns
`include "ssr_consts.vh"
module ssr_slave_props #(
  parameter TIMEOUT_CYCLES = `SSR_TIMEOUT_CYCLES
) (
  input wire       clk_sys,
  input wire       reset_n,
  input wire       scl_in,
  input wire       sda_oe,
  input wire       sda_out,
  input wire [7:0] reg_addr,
  input wire       reg_we
);
  reg [31:0] low_q;
  reg [7:0]  wa_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  always @(posedge clk_sys)
  begin
    low_q <= scl_in ? 32'h0000_0000 : low_q + 32'h0000_0001;
    if (reg_we)
      wa_q <= reg_addr;
  end
  a_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_oe_in_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("data line moved while clock high");
  a_oe_stands: assert property ($rose(sda_oe) |=> sda_oe [*4])
    else $error("data line drive too short");
  a_we_single: assert property (reg_we |=> !reg_we)
    else $error("write strobe longer than one cycle");
  a_we_in_low: assert property (reg_we |-> !scl_in)
    else $error("write strobe outside clock low");
  a_we_step: assert property (reg_we |-> ##[1:60] reg_addr == wa_q + 8'h01)
    else $error("pointer did not step after write");
  a_timeout_free: assert property (low_q > TIMEOUT_CYCLES + 16 |-> !sda_oe)
    else $error("data line held after clock timeout");
  a_reset_quiet: assert property (disable iff (1'b0)
    !reset_n |=> !sda_oe && !reg_we && reg_addr == 8'h00)
    else $error("outputs not idle after reset");
endmodule // ssr_slave_props
bind ssr_slave ssr_slave_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_ssr_slave_props (
  .clk_sys  (clk_sys),
  .reset_n  (reset_n),
  .scl_in   (scl_in),
  .sda_oe   (sda_oe),
  .sda_out  (sda_out),
  .reg_addr (reg_addr),
  .reg_we   (reg_we)
);

// ---- bench/ssr_mst.sv ----
// Bus master model: clock and open-drain data toward the slave
`timescale 1ns/1ns
module ssr_mst (
  input  wire clk_sys,
  input  wire sda_in,
  output reg  scl,
  output reg  sda_m
);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task start;
    sda_m <= 1'b0;
    repeat (4) @(posedge clk_sys);
    scl <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task stop;
    sda_m <= 1'b0;
    repeat (4) @(posedge clk_sys);
    scl <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sda_m <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
  // Data moves 2 cycles after the fall, past the slave's synchroniser
  task bit_x(input logic b, output logic r);
    sda_m <= b;
    repeat (4) @(posedge clk_sys);
    scl <= 1'b1;
    repeat (2) @(posedge clk_sys);
    r = sda_in;
    scl <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task xfer(input logic [7:0] d, input logic nak, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(nak, a);
  endtask
endmodule // ssr_mst

// ---- bench/ssr_slave_tb.sv ----
// Self-checking testbench for the serial slave read path
`timescale 1ns/1ns
`include "ssr_consts.vh"
module ssr_slave_tb;
  localparam TO = 200;
  reg        clk_sys = 1'b0;
  reg        reset_n = 1'b0;
  reg        pin     = 1'b0;
  wire       scl, sda_m, sda_oe, sda_out, reg_we;
  wire [7:0] reg_addr, reg_wdata;
  wire       sda       = sda_m & ~sda_oe;
  wire [7:0] reg_rdata = reg_addr ^ 8'h5a;
  int        fail_count  = 0;
  int        checks_done = 0;
  logic [7:0] q, wa, wd;
  logic       a;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (reg_we)
    begin
      wa <= reg_addr;
      wd <= reg_wdata;
    end
  ssr_slave #(.TIMEOUT_CYCLES(TO)) i_ssr_slave (.clk_sys(clk_sys), .reset_n(reset_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin(pin), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_wdata(reg_wdata), .reg_we(reg_we));
  ssr_mst i_ssr_mst (.clk_sys(clk_sys), .sda_in(sda), .scl(scl), .sda_m(sda_m));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task adr_ack(input logic b0, input logic rw, input logic [7:0] e);
    i_ssr_mst.start;
    i_ssr_mst.xfer({`SSR_ADDR_FIXED, b0, rw}, 1'b1, q, a);
    chk("addr ack", e, {7'h00, a});
  endtask
  task t_write;
    adr_ack(1'b0, 1'b0, 8'h00);
    i_ssr_mst.xfer(8'h10, 1'b1, q, a);
    i_ssr_mst.xfer(8'h3c, 1'b1, q, a);
    chk("wr addr", 8'h10, wa);
    chk("wr data", 8'h3c, wd);
    i_ssr_mst.xfer(8'h7e, 1'b1, q, a);
    chk("wr addr", 8'h11, wa);
    i_ssr_mst.stop;
    $display("test write done");
  endtask
  task t_read;
    adr_ack(1'b0, 1'b1, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      i_ssr_mst.xfer(8'hff, k == 2, q, a);
      chk("rd data", (8'h12 + k[7:0]) ^ 8'h5a, q);
    end
    chk("nack release", 8'h01, {7'h00, a});
    // Next byte would start with a zero here if the slave ignored the NACK
    repeat (4) @(posedge clk_sys);
    chk("nack oe", 8'h00, {7'h00, sda_oe});
    i_ssr_mst.stop;
    $display("test read done");
  endtask
  task t_pin;
    pin <= 1'b1;
    adr_ack(1'b1, 1'b1, 8'h00);
    i_ssr_mst.xfer(8'hff, 1'b1, q, a);
    chk("rd kept ptr", 8'h15 ^ 8'h5a, q);
    i_ssr_mst.stop;
    adr_ack(1'b0, 1'b1, 8'h01);
    i_ssr_mst.stop;
    $display("test select done");
  endtask
  // Clock parked low in the ack slot until the interface gives up
  task t_timeout;
    logic [7:0] ab;
    ab = {`SSR_ADDR_FIXED, 2'b11};
    i_ssr_mst.start;
    for (int i = 7; i >= 0; i--)
      i_ssr_mst.bit_x(ab[i], a);
    repeat (6) @(posedge clk_sys);
    chk("ack drive", 8'h01, {7'h00, sda_oe});
    chk("sda level", 8'h00, {7'h00, sda_out});
    repeat (TO + 20) @(posedge clk_sys);
    chk("timeout", 8'h00, {7'h00, sda_oe});
    i_ssr_mst.stop;
    adr_ack(1'b1, 1'b1, 8'h00);
    i_ssr_mst.xfer(8'hff, 1'b1, q, a);
    chk("rd after timeout", 8'h16 ^ 8'h5a, q);
    i_ssr_mst.stop;
    $display("test timeout done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    t_write;
    t_read;
    t_pin;
    t_timeout;
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    give_verdict;
  end
endmodule // ssr_slave_tb
